// [verilog/rip_top.sv]
// Shared open-drain interrupt pin multiplexer of a serial real-time clock, with APB registers.
// Assumes timer, alarm and watchdog logic on the same clock, and an external pull-up on the pin.
//
// Operation
// - Enabled set oscillator-fail flag pulls the shared pin low, priority permitting.
// - Only writing the oscillator-fail flag to zero releases it; reads do nothing.
// - Clearing the enable releases the pin; re-enabling with flag set asserts at once.
// - Backup enable plus oscillator-fail enable lets oscillator failure assert in backup.
// - Pin is open drain, only pulls low; the host supplies the pull-up.
// - Timer, oscillator-fail, alarm 1 and watchdog are ORed into one request.
// - Frequency-test bit puts a 512 Hz square wave on the pin.
// - Main supply uses four sources; backup keeps only alarm 1 and oscillator-fail.
// - Main supply, level bit 0, frequency test 0: pin driven low.
// - Main supply, frequency test 1: square wave if level 0 or nothing enabled.
// - Main supply, level 1, something enabled: pin high until an enabled request or a watchdog timeout pends.
// - Main supply, level 1, frequency test 0, nothing enabled: pin released.
// - Backup mode ignores the frequency-test bit entirely.
// - Backup mode with backup enable 0: pin released whatever else.
// - Backup mode, level 1, neither alarm 1 nor oscillator-fail enabled: released.
// - Backup mode, backup enable 1, level 0: pin driven low.
// - Level bit is bit 7, frequency test bit 6, of register 08h.
// - Alarm 1 enable is bit 7, backup enable bit 5, of register 0Ah.
// - Oscillator-fail enable is bit 7 of 09h; timer enable bit 5 of 11h.
// - Further flags while low cause no extra edge; low until all serviced.
// - Oscillator stop sets the flag; it stays until written zero.
`timescale 1ns/10ps
`default_nettype none
`include "rip_defines.svh"

module rip_top #(
   parameter int unsigned FT_HALF_CYC = `RIP_FT_HALF_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_b_i,
   // APB slave.
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Power state and source conditions.
   input  wire logic        backup_mode_i,
   input  wire logic        osc_stop_i,
   input  wire logic        timer_flag_i,
   input  wire logic        alarm1_flag_i,
   input  wire logic        watchdog_timeout_i,
   input  wire logic        watchdog_running_i,
   // Open-drain shared pin.
   input  wire logic        shared_irq_pin_i,
   output logic             shared_irq_pin_o,
   output logic             shared_irq_pin_oe_o
);

   // Synchronised asynchronous inputs: backup mode, oscillator stop, pin readback.
   logic [2:0]  sync1_q;
   logic [2:0]  sync2_q;
   wire         backup_s  = sync2_q[0];
   wire         osc_stop_s = sync2_q[1];
   wire         pin_s     = sync2_q[2];

   // Control registers and the sticky flag.
   rip_pkg::rip_cfg_s cfg_q;
   rip_pkg::rip_cfg_s cfg_d;
   logic        osc_fail_flag_q;
   logic        osc_fail_flag_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // Square wave divider.
   logic [14:0] sq_cnt_q;
   logic        sq_q;

   // Address decode, shared by read and write paths.
   function automatic logic is_idx(input logic [7:0] addr, input logic [5:0] idx);
      is_idx = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
   endfunction

   wire         sel_calib  = is_idx(paddr_i, `RIP_IDX_CALIB);
   wire         sel_wdog   = is_idx(paddr_i, `RIP_IDX_WDOG);
   wire         sel_alm    = is_idx(paddr_i, `RIP_IDX_ALM1_MON);
   wire         sel_flags  = is_idx(paddr_i, `RIP_IDX_FLAGS);
   wire         sel_tmr    = is_idx(paddr_i, `RIP_IDX_TMR_CTRL);
   wire         sel_stat   = is_idx(paddr_i, `RIP_IDX_PIN_STAT);
   wire         mapped     = sel_calib | sel_wdog | sel_alm | sel_flags | sel_tmr | sel_stat;
   wire         setup_ph   = psel_i & ~penable_i;
   wire         access_ph  = psel_i & penable_i;
   wire         wr_en      = access_ph & pwrite_i & mapped;

   // Zero wait states; an unmapped address answers with an error in the access phase.
   assign pready_o  = 1'b1;
   assign pslverr_o = access_ph & ~mapped;
   assign prdata_o  = prdata_q;

   // Request terms: timer, oscillator-fail and alarm 1 gated by their enables, then ORed with the watchdog; backup drops timer and watchdog.
   // The watchdog timeout is not gated at all; a running watchdog only counts toward the main-supply enable.
   wire         req_timer  = timer_flag_i & cfg_q.timer_irq_enable;
   wire         req_osc    = osc_fail_flag_q & cfg_q.osc_fail_irq_enable;
   wire         req_alarm  = alarm1_flag_i & cfg_q.alarm1_irq_enable;
   wire         irq_main   = req_timer | req_osc | req_alarm | watchdog_timeout_i;
   wire         irq_backup = req_osc | req_alarm;
   wire         en_main    = cfg_q.alarm1_irq_enable | cfg_q.osc_fail_irq_enable |
                             cfg_q.timer_irq_enable | watchdog_running_i;
   wire         en_backup  = cfg_q.alarm1_irq_enable | cfg_q.osc_fail_irq_enable;
   wire         irq_req    = backup_s ? irq_backup : irq_main;

   // Main supply, strongest first: a low level bit with the test bit clear forces the pin low;
   // the test bit then gives the square wave if the level bit is low or nothing is enabled;
   // with the level bit high and something enabled the request owns the pin; else released.
   // Backup: a clear backup enable releases the pin, then a low level bit pulls it low, then
   // the two backup sources own it; the test bit is not consulted, so a stale calibration
   // setting cannot toggle the pin on battery. A running watchdog counts as an enable, which
   // hands the pin to the request logic and silences the square wave while the level bit is high.
   // Priority selection; combinational so the pin follows mode and flags without a bus access.
   function automatic rip_pkg::rip_src_e pick_src(input logic bk, input rip_pkg::rip_cfg_s c,
                                                  input logic enm, input logic enb);
      if (bk) begin
         if (!c.backup_irq_enable) begin
            pick_src = rip_pkg::RIP_SRC_HIGH;
         end else if (!c.out_level) begin
            pick_src = rip_pkg::RIP_SRC_LOW;
         end else if (enb) begin
            pick_src = rip_pkg::RIP_SRC_IRQ;
         end else begin
            pick_src = rip_pkg::RIP_SRC_HIGH;
         end
      end else begin
         if (!c.out_level && !c.freq_test_enable) begin
            pick_src = rip_pkg::RIP_SRC_LOW;
         end else if (c.freq_test_enable && (!c.out_level || !enm)) begin
            pick_src = rip_pkg::RIP_SRC_SQUARE;
         end else if (enm) begin
            pick_src = rip_pkg::RIP_SRC_IRQ;
         end else begin
            pick_src = rip_pkg::RIP_SRC_HIGH;
         end
      end
   endfunction

   rip_pkg::rip_src_e src;
   logic              pin_level;

   // Pin level from the chosen owner; a pending request holds it low as one level.
   always_comb begin
      src = pick_src(backup_s, cfg_q, en_main, en_backup);
      case (src)
         rip_pkg::RIP_SRC_LOW:    pin_level = 1'b0;
         rip_pkg::RIP_SRC_HIGH:   pin_level = 1'b1;
         rip_pkg::RIP_SRC_SQUARE: pin_level = sq_q;
         rip_pkg::RIP_SRC_IRQ:    pin_level = ~irq_req;
         default:                 pin_level = 1'b1;
      endcase
   end

   // Open drain: the output value is always low and only the enable moves.
   // Driving the data high would fight the host's pull-up and any other device on the wire.
   assign shared_irq_pin_o    = 1'b0;
   assign shared_irq_pin_oe_o = ~pin_level;

   // Register write decode with field placement.
   always_comb begin
      cfg_d = cfg_q;
      if (wr_en && sel_calib) begin
         cfg_d.out_level        = pwdata_i[`RIP_BIT_OUT];
         cfg_d.freq_test_enable = pwdata_i[`RIP_BIT_FREQ_TEST];
      end
      if (wr_en && sel_wdog) begin
         cfg_d.osc_fail_irq_enable = pwdata_i[`RIP_BIT_OSC_IRQ_EN];
      end
      if (wr_en && sel_alm) begin
         cfg_d.alarm1_irq_enable = pwdata_i[`RIP_BIT_ALM_IRQ_EN];
         cfg_d.backup_irq_enable = pwdata_i[`RIP_BIT_BKP_IRQ_EN];
      end
      if (wr_en && sel_tmr) begin
         cfg_d.timer_irq_enable = pwdata_i[`RIP_BIT_TMR_IRQ_EN];
      end
   end

   // Sticky flag: a stop in the same cycle as a clearing write keeps the flag set.
   // Losing a stop event would hide a clock fault, so the set side must dominate.
   wire of_clear = wr_en & sel_flags & ~pwdata_i[`RIP_BIT_OSC_FAIL];
   assign osc_fail_flag_d = osc_stop_s | (osc_fail_flag_q & ~of_clear);

   // Read mux, captured in the setup phase so read data comes from a flip-flop.
   // Limitation: a flag that moves during the access phase shows up only on the next read.
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (sel_calib) begin
         prdata_d[`RIP_BIT_OUT] = cfg_q.out_level;
         prdata_d[`RIP_BIT_FREQ_TEST] = cfg_q.freq_test_enable;
      end
      if (sel_wdog) begin
         prdata_d[`RIP_BIT_OSC_IRQ_EN] = cfg_q.osc_fail_irq_enable;
      end
      if (sel_alm) begin
         prdata_d[`RIP_BIT_ALM_IRQ_EN] = cfg_q.alarm1_irq_enable;
         prdata_d[`RIP_BIT_BKP_IRQ_EN] = cfg_q.backup_irq_enable;
      end
      if (sel_tmr) begin
         prdata_d[`RIP_BIT_TMR_IRQ_EN] = cfg_q.timer_irq_enable;
      end
      if (sel_flags) begin
         prdata_d[`RIP_BIT_WDOG_FLAG] = watchdog_timeout_i;
         prdata_d[`RIP_BIT_ALM_FLAG]  = alarm1_flag_i;
         prdata_d[`RIP_BIT_TMR_FLAG]  = timer_flag_i;
         prdata_d[`RIP_BIT_OSC_FAIL]  = osc_fail_flag_q;
      end
      if (sel_stat) begin
         prdata_d[`RIP_BIT_STAT_PIN]    = pin_s;
         prdata_d[`RIP_BIT_STAT_BACKUP] = backup_s;
         prdata_d[`RIP_BIT_STAT_IRQ]    = irq_req;
      end
   end

   // Two-stage synchronisers; the first stage feeds only the second.
   // A mode change therefore reaches the pin two clocks late, and the status word shows the same lag.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {shared_irq_pin_i, osc_stop_i, backup_mode_i};
         sync2_q <= sync1_q;
      end
   end

   // Configuration, flag and read data registers.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_q           <= '{`RIP_RST_OUT, `RIP_RST_FREQ_TEST, `RIP_RST_OSC_IRQ_EN,
                              `RIP_RST_ALM_IRQ_EN, `RIP_RST_BKP_IRQ_EN, `RIP_RST_TMR_IRQ_EN};
         osc_fail_flag_q <= `RIP_RST_OSC_FAIL;
         prdata_q        <= 32'h0000_0000;
      end else begin
         cfg_q           <= cfg_d;
         osc_fail_flag_q <= osc_fail_flag_d;
         if (setup_ph && !pwrite_i) begin
            prdata_q <= prdata_d;
         end
      end
   end

   // The divider runs free; backup mode simply never selects the square wave.
   // Running free costs a little power but avoids a phase jump when the test bit is set.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sq_cnt_q <= 15'h0000;
         sq_q     <= 1'b0;
      end else if (sq_cnt_q == 15'(FT_HALF_CYC - 1)) begin
         sq_cnt_q <= 15'h0000;
         sq_q     <= ~sq_q;
      end else begin
         sq_cnt_q <= sq_cnt_q + 15'h0001;
      end
   end

   // Checks on the pin priority, the sticky flag and the divider.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   a_main_out_low: assert property (
      !backup_s && !cfg_q.out_level && !cfg_q.freq_test_enable |-> shared_irq_pin_oe_o)
      else $error("Pin not low with level and test bits clear on main supply.");
   a_main_release: assert property (
      !backup_s && cfg_q.out_level && !cfg_q.freq_test_enable && !en_main |-> !shared_irq_pin_oe_o)
      else $error("Pin not released with nothing enabled on main supply.");
   a_main_square: assert property (
      !backup_s && cfg_q.freq_test_enable && !cfg_q.out_level |-> shared_irq_pin_oe_o == !sq_q)
      else $error("Pin does not follow the square wave in frequency test.");
   a_main_osc_irq: assert property (
      !backup_s && cfg_q.out_level && !cfg_q.freq_test_enable && req_osc |-> shared_irq_pin_oe_o)
      else $error("Enabled oscillator fail does not pull the pin low.");
   a_osc_en_reassert: assert property (
      !backup_s && cfg_q.out_level && !cfg_q.freq_test_enable && osc_fail_flag_q && wr_en && sel_wdog
      && pwdata_i[`RIP_BIT_OSC_IRQ_EN] && !osc_stop_s |=> shared_irq_pin_oe_o)
      else $error("Re-enabling with the flag set does not assert the pin next cycle.");
   a_backup_abe_off: assert property (
      backup_s && !cfg_q.backup_irq_enable |-> !shared_irq_pin_oe_o)
      else $error("Pin driven in backup with backup enable clear.");
   a_backup_out_low: assert property (
      backup_s && cfg_q.backup_irq_enable && !cfg_q.out_level |-> shared_irq_pin_oe_o)
      else $error("Pin not low in backup with level bit clear.");
   a_backup_no_en: assert property (
      backup_s && cfg_q.out_level && !en_backup |-> !shared_irq_pin_oe_o)
      else $error("Pin driven in backup with no enabled source.");
   a_backup_osc: assert property (
      backup_s && cfg_q.backup_irq_enable && cfg_q.out_level && req_osc |-> shared_irq_pin_oe_o)
      else $error("Oscillator fail does not assert the pin in backup.");
   a_backup_timer_off: assert property (
      backup_s && cfg_q.backup_irq_enable && cfg_q.out_level && en_backup && !irq_backup
      |-> !shared_irq_pin_oe_o)
      else $error("Timer or watchdog asserts the pin in backup.");
   a_of_set_sticky: assert property (
      osc_stop_s |=> osc_fail_flag_q)
      else $error("Oscillator stop does not set the flag.");
   a_of_read_keeps: assert property (
      osc_fail_flag_q && !of_clear |=> osc_fail_flag_q)
      else $error("Flag cleared without a write of zero.");
   a_sq_toggle: assert property (
      $changed(sq_q) |-> $past(sq_cnt_q) == 15'(FT_HALF_CYC - 1))
      else $error("Square wave toggles off its half period.");

   // Main supply: once the level bit is set and something is enabled, the request owns the pin.
   a_main_irq_low: assert property (
      !backup_s && cfg_q.out_level && en_main && irq_main |-> shared_irq_pin_oe_o)
      else $error("Pending request does not pull the pin low.");

   a_main_irq_idle: assert property (
      !backup_s && cfg_q.out_level && en_main && !irq_main |-> !shared_irq_pin_oe_o)
      else $error("Pin driven with no pending request.");

   a_main_wdog_src: assert property (
      !backup_s && cfg_q.out_level && watchdog_running_i && watchdog_timeout_i |-> shared_irq_pin_oe_o)
      else $error("Watchdog timeout does not pull the pin low.");

   a_main_ft_free: assert property (
      !backup_s && cfg_q.freq_test_enable && !en_main |-> shared_irq_pin_oe_o == !sq_q)
      else $error("Square wave missing with nothing enabled.");

   a_enable_off_rel: assert property (
      !backup_s && cfg_q.out_level && !cfg_q.freq_test_enable && !cfg_q.osc_fail_irq_enable
      && !req_timer && !req_alarm && !watchdog_timeout_i |-> !shared_irq_pin_oe_o)
      else $error("Pin held after the oscillator-fail enable was cleared.");

   // Backup: only alarm 1 and oscillator fail count, and the test bit is ignored.
   a_backup_irq_low: assert property (
      backup_s && cfg_q.backup_irq_enable && cfg_q.out_level && irq_backup |-> shared_irq_pin_oe_o)
      else $error("Backup request does not pull the pin low.");

   a_backup_ft_off: assert property (
      backup_s |-> src != rip_pkg::RIP_SRC_SQUARE)
      else $error("Square wave selected in backup.");

   // A written zero clears the flag when no stop arrives in the same cycle.
   a_osc_clear_works: assert property (
      of_clear && !osc_stop_s |=> !osc_fail_flag_q)
      else $error("Written zero does not clear the flag.");

   // Register fields land where software expects them.
   a_wr_calib: assert property (
      wr_en && sel_calib |=> cfg_q.out_level == $past(pwdata_i[`RIP_BIT_OUT])
      && cfg_q.freq_test_enable == $past(pwdata_i[`RIP_BIT_FREQ_TEST]))
      else $error("Calibration write lost a field.");

   a_wr_alarm: assert property (
      wr_en && sel_alm |=> cfg_q.alarm1_irq_enable == $past(pwdata_i[`RIP_BIT_ALM_IRQ_EN])
      && cfg_q.backup_irq_enable == $past(pwdata_i[`RIP_BIT_BKP_IRQ_EN]))
      else $error("Alarm month write lost a field.");

   a_wr_osc_en: assert property (
      wr_en && sel_wdog |=> cfg_q.osc_fail_irq_enable == $past(pwdata_i[`RIP_BIT_OSC_IRQ_EN]))
      else $error("Watchdog write lost the oscillator-fail enable.");

   a_wr_timer_en: assert property (
      wr_en && sel_tmr |=> cfg_q.timer_irq_enable == $past(pwdata_i[`RIP_BIT_TMR_IRQ_EN]))
      else $error("Timer control write lost the timer enable.");

   // The divider count never passes its end point.
   a_sq_range: assert property (
      sq_cnt_q < 15'(FT_HALF_CYC))
      else $error("Divider count out of range.");

   c_main_irq: cover property (!backup_s && src == rip_pkg::RIP_SRC_IRQ && shared_irq_pin_oe_o);
   c_backup_irq: cover property (backup_s && src == rip_pkg::RIP_SRC_IRQ && shared_irq_pin_oe_o);
   c_of_clear: cover property (osc_fail_flag_q ##1 !osc_fail_flag_q);
   c_square: cover property (src == rip_pkg::RIP_SRC_SQUARE && $changed(sq_q));
   c_backup_released: cover property (backup_s && !cfg_q.backup_irq_enable && !shared_irq_pin_oe_o);

endmodule
`default_nettype wire

// [verilog/rip_defines.svh]
// Constants for the shared interrupt pin multiplexer: register indices, bit positions,
// reset values and timing counts. Assumes a 20 MHz system clock.
`ifndef RIP_DEFINES_SVH
`define RIP_DEFINES_SVH

// Register indices; the APB byte address is four times the index.
`define RIP_IDX_CALIB      6'h08
`define RIP_IDX_WDOG       6'h09
`define RIP_IDX_ALM1_MON   6'h0A
`define RIP_IDX_FLAGS      6'h0F
`define RIP_IDX_TMR_CTRL   6'h11
`define RIP_IDX_PIN_STAT   6'h18

// Field positions.
`define RIP_BIT_OUT        7
`define RIP_BIT_FREQ_TEST    6
`define RIP_BIT_OSC_IRQ_EN   7
`define RIP_BIT_ALM_IRQ_EN   7
`define RIP_BIT_BKP_IRQ_EN   5
`define RIP_BIT_TMR_IRQ_EN   5
`define RIP_BIT_WDOG_FLAG    7
`define RIP_BIT_ALM_FLAG     6
`define RIP_BIT_TMR_FLAG     3
`define RIP_BIT_OSC_FAIL     2
`define RIP_BIT_STAT_PIN     0
`define RIP_BIT_STAT_BACKUP  1
`define RIP_BIT_STAT_IRQ     2

// Reset values of the control bits and of the sticky oscillator-fail flag.
`define RIP_RST_OUT        1'b1
`define RIP_RST_FREQ_TEST  1'b0
`define RIP_RST_OSC_IRQ_EN 1'b0
`define RIP_RST_ALM_IRQ_EN 1'b0
`define RIP_RST_BKP_IRQ_EN 1'b0
`define RIP_RST_TMR_IRQ_EN 1'b0
`define RIP_RST_OSC_FAIL   1'b1

// Timing: frequency-test rate and the derived half period in system clocks.
`define RIP_CLK_HZ         20000000
`define RIP_FT_FREQ_HZ     512
`define RIP_FT_HALF_CYC    (`RIP_CLK_HZ / (2 * `RIP_FT_FREQ_HZ))

`endif

// [verilog/rip_pkg.sv]
// Types shared by the shared interrupt pin multiplexer.
// Assumes the constants of rip_defines.svh for field meaning.
package rip_pkg;

   // Configuration bits that steer the pin selection.
   typedef struct packed {
      logic out_level;
      logic freq_test_enable;
      logic osc_fail_irq_enable;
      logic alarm1_irq_enable;
      logic backup_irq_enable;
      logic timer_irq_enable;
   } rip_cfg_s;

   // What currently owns the shared pin.
   typedef enum logic [1:0] {
      RIP_SRC_LOW,
      RIP_SRC_HIGH,
      RIP_SRC_SQUARE,
      RIP_SRC_IRQ
   } rip_src_e;

endpackage

// [testbench/rip_host_model.sv]
// Host interrupt input model: pull-up on the shared pin and a count of falling edges.
// Assumes the device pulls the pin low only while its output enable is high.
`timescale 1ns/10ps
`default_nettype none

module rip_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_b_i,
   input  wire logic       pin_oe_i,
   input  wire logic       pin_o_i,
   output logic            pin_level_o,
   output logic [7:0]      fall_count_o
);
   logic prev_q;

   // A released pin goes to the pull-up level, never to a held value.
   assign pin_level_o = pin_oe_i ? pin_o_i : 1'b1;

   // Falling edges seen at the host input, so a missing or extra edge shows up.
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_q       <= 1'b1;
         fall_count_o <= 8'h00;
      end else begin
         prev_q <= pin_level_o;
         if (prev_q && !pin_level_o) begin
            fall_count_o <= fall_count_o + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// [testbench/rip_top_tb.sv]
// Self-checking bench for the shared interrupt pin multiplexer, driven over APB.
// Assumes zero wait state APB and a host model with pull-up on the pin.
`timescale 1ns/10ps
`default_nettype none
`include "rip_defines.svh"

module rip_top_tb;
   localparam int unsigned HALF  = 8;
   localparam logic [7:0]  A_CAL = {`RIP_IDX_CALIB, 2'b00};
   localparam logic [7:0]  A_WDG = {`RIP_IDX_WDOG, 2'b00};
   localparam logic [7:0]  A_ALM = {`RIP_IDX_ALM1_MON, 2'b00};
   localparam logic [7:0]  A_FLG = {`RIP_IDX_FLAGS, 2'b00};
   localparam logic [7:0]  A_TMR = {`RIP_IDX_TMR_CTRL, 2'b00};
   localparam logic [7:0]  A_STA = {`RIP_IDX_PIN_STAT, 2'b00};
   logic        clk_sys_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic        backup, osc_stop, wd_run, pin_level, pin_o, pin_oe;
   logic [7:0]  paddr, falls, f0;
   logic [31:0] pwdata, prdata;
   logic [2:0]  src;
   int          fail_count, comparisons, cycles;

   rip_top #(.FT_HALF_CYC(HALF)) rip_top_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .backup_mode_i(backup), .osc_stop_i(osc_stop),
      .timer_flag_i(src[0]), .alarm1_flag_i(src[1]), .watchdog_timeout_i(src[2]),
      .watchdog_running_i(wd_run), .shared_irq_pin_i(pin_level), .shared_irq_pin_o(pin_o),
      .shared_irq_pin_oe_o(pin_oe));

   rip_host_model rip_host_model_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pin_oe_i(pin_oe),
      .pin_o_i(pin_o), .pin_level_o(pin_level), .fall_count_o(falls));

   // Compare tasks, one for words and one for single pin levels.
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %0b seen %0b", name, exp, got);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_sys_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic eerr);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h00000000, rd, er);
      chk_word(name, exp, rd);
      chk_bit(name, eerr, er);
   endtask

   // The pin is combinational, so it is looked at in the middle of the following cycle.
   task automatic pin_chk(input string name, input logic exp);
      @(negedge clk_sys_i);
      chk_bit(name, exp, pin_level);
   endtask

   task automatic set_src(input logic [2:0] v);
      @(posedge clk_sys_i);
      src <= v;
   endtask

   // Counts pin changes over 64 sample intervals; a free square wave gives 64 / HALF.
   task automatic sq_chk(input string name, input logic [31:0] exp);
      logic        last;
      logic [31:0] cnt;
      cnt = 32'h00000000;
      @(negedge clk_sys_i);
      last = pin_level;
      repeat (64) begin
         @(negedge clk_sys_i);
         if (pin_level !== last) cnt++;
         last = pin_level;
      end
      chk_word(name, exp, cnt);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // A hang ends the run as a mismatch; the sequence needs well under a thousand cycles.
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 4000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      {rst_b_i, psel, penable, pwrite, backup, osc_stop, wd_run} = 7'h00;
      {paddr, pwdata, src} = 43'h0;
      repeat (8) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rd_chk("calib_reset", A_CAL, 32'h00000080, 1'b0);
      rd_chk("flags_reset", A_FLG, 32'h00000004, 1'b0);
      rd_chk("unmapped", 8'h04, 32'h00000000, 1'b1);
      pin_chk("pin_reset", 1'b1);
      rd_chk("status_idle", A_STA, 32'h00000001, 1'b0);
      wr(A_WDG, 32'h00000080);
      pin_chk("of_irq", 1'b0);
      rd_chk("flags_read", A_FLG, 32'h00000004, 1'b0);
      pin_chk("of_after_read", 1'b0);
      f0 = falls;
      set_src(3'b100);
      pin_chk("second_flag", 1'b0);
      chk_word("no_extra_edge", {24'h0, f0}, {24'h0, falls});
      set_src(3'b000);
      wr(A_WDG, 32'h00000000);
      pin_chk("osc_fail_irq_enable_off", 1'b1);
      wr(A_WDG, 32'h00000080);
      pin_chk("osc_fail_irq_enable_on", 1'b0);
      wr(A_FLG, 32'h00000000);
      pin_chk("of_clear", 1'b1);
      rd_chk("flags_clear", A_FLG, 32'h00000000, 1'b0);
      wr(A_TMR, 32'h00000020);
      wr(A_ALM, 32'h00000080);
      wd_run <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         set_src(3'b001 << i);
         pin_chk("main_source", 1'b0);
         set_src(3'b000);
         pin_chk("main_idle", 1'b1);
      end
      wr(A_CAL, 32'h000000C0);
      sq_chk("ft_irq_mode", 32'h00000000);
      wr(A_CAL, 32'h00000000);
      pin_chk("out_low", 1'b0);
      wr(A_CAL, 32'h00000040);
      sq_chk("ft_out_low", 64 / HALF);
      wr(A_WDG, 32'h00000000);
      wr(A_TMR, 32'h00000000);
      wr(A_ALM, 32'h00000000);
      wd_run <= 1'b0;
      wr(A_CAL, 32'h000000C0);
      sq_chk("ft_no_enable", 64 / HALF);
      wr(A_CAL, 32'h00000000);
      @(posedge clk_sys_i);
      backup <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      pin_chk("backup_abe_off", 1'b1);
      wr(A_ALM, 32'h00000020);
      pin_chk("backup_out_low", 1'b0);
      wr(A_CAL, 32'h00000040);
      sq_chk("backup_ft", 32'h00000000);
      wr(A_CAL, 32'h00000080);
      wr(A_TMR, 32'h00000020);
      wd_run <= 1'b1;
      set_src(3'b101);
      pin_chk("backup_no_enable", 1'b1);
      set_src(3'b000);
      wr(A_WDG, 32'h00000080);
      pin_chk("backup_of_clear", 1'b1);
      @(posedge clk_sys_i);
      osc_stop <= 1'b1;
      @(posedge clk_sys_i);
      osc_stop <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      pin_chk("backup_osc_fail", 1'b0);
      wr(A_FLG, 32'h00000000);
      pin_chk("backup_of_serviced", 1'b1);
      wr(A_ALM, 32'h000000A0);
      set_src(3'b010);
      pin_chk("backup_alarm", 1'b0);
      rd_chk("flags_alarm", A_FLG, 32'h00000040, 1'b0);
      rd_chk("status_backup", A_STA, 32'h00000006, 1'b0);
      end_of_test();
   end
endmodule

`default_nettype wire
